// ==== design/uen_core.sv ====
// Unvoiced excitation decoding and background noise smoothing core with APB registers.
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "uen_params.svh"

module uen_core (
	// Clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     rst,
	// Register bus
	input  wire uen_pkg::uen_apb_req_type apb_req,
	output uen_pkg::uen_apb_rsp_type      apb_rsp
);

	// ------------------------------------------------------------------------
	// Arithmetic helpers
	// ------------------------------------------------------------------------
	function automatic uen_pkg::uen_q_type mulq(input uen_pkg::uen_q_type a, input uen_pkg::uen_q_type b);
		logic signed [35:0] p;
		p = a * b;
		mulq = p[32:15];
	endfunction

	function automatic logic [15:0] sat16(input logic signed [31:0] v);
		if (v > 32'sh00007fff) begin
			sat16 = 16'h7fff;
		end else if (v < -32'sh00008000) begin
			sat16 = 16'h8000;
		end else begin
			sat16 = v[15:0];
		end
	endfunction

	// The random codebook is a fixed hash of vector index and position.
	function automatic logic signed [31:0] cb_val(input logic [6:0] idx, input logic [5:0] pos, input logic neg);
		logic [15:0] h;
		h = (16'(idx) * 16'h9e37) ^ (16'(pos) * 16'h7f4b);
		cb_val = neg ? -32'(signed'(h[8:0])) : 32'(signed'(h[8:0]));
	endfunction

	function automatic uen_pkg::uen_q_type blend(input uen_pkg::uen_q_type f, input uen_pkg::uen_q_type dv,
		input uen_pkg::uen_q_type b);
		blend = mulq(`UEN_Q_ONE - b, f) + mulq(b, dv);
	endfunction

	// ------------------------------------------------------------------------
	// State and helpers
	// ------------------------------------------------------------------------
	uen_pkg::uen_core_st_type q;
	uen_pkg::uen_core_st_type d;
	logic               div_done;
	logic [15:0]        div_quot;
	logic               sq_done;
	logic [15:0]        sq_root;
	logic               acc;
	logic               wr;
	logic               rate_ok;
	logic               on;
	logic [7:0]         addr;
	logic [31:0]        wdata;
	logic [3:0]         li;
	logic signed [31:0] inn;
	uen_pkg::uen_q_type x;
	uen_pkg::uen_q_type xp;
	uen_pkg::uen_q_type t16;
	uen_pkg::uen_q_type n3;
	uen_pkg::uen_q_type rn;
	uen_pkg::uen_q_type g;
	uen_pkg::uen_q_type fmid;
	logic signed [31:0] tilt;
	logic signed [31:0] mix;
	logic [31:0]        sq;
	logic signed [31:0] cr;
	logic [31:0]        r0n;
	logic signed [31:0] r1n;
	logic signed [35:0] pa;
	logic signed [35:0] pw;

	uen_div u_div (
		.ref_clk (ref_clk),
		.rst     (rst),
		.go      (q.div_go),
		.num     (q.div_num),
		.den     (q.div_den),
		.done    (div_done),
		.quot    (div_quot)
	);

	uen_sqrt u_sqrt (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.go       (q.sq_go),
		.radicand (q.sq_x),
		.done     (sq_done),
		.root     (sq_root)
	);

	// ------------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------------
	always_comb begin
		d = q;
		d.div_go = 1'b0;
		d.sq_go = 1'b0;
		d.pslverr = 1'b0;
		addr = apb_req.paddr;
		wdata = apb_req.pwdata;
		li = q.lsp_sel;
		acc = apb_req.psel && apb_req.penable;
		wr = acc && q.pready && apb_req.pwrite;
		rate_ok = (q.bw == `UEN_BW_NB) ? (q.rate == `UEN_RATE_LIMIT) : (q.rate <= `UEN_RATE_LIMIT);
		on = 1'b0;
		g = q.gamma - `UEN_GAMMA_STEP;
		pa = 36'sh0;
		pw = 36'sh0;
		// Innovation of two signed random vectors scaled by 6 dB gain steps.
		inn = (cb_val(q.unv_param[6:0], q.smp_cnt[5:0], q.unv_param[7])
			+ cb_val(q.unv_param[14:8], q.smp_cnt[5:0], q.unv_param[15])) <<< q.unv_param[19:16];
		x = q.unv_mode ? 18'(signed'(sat16(inn))) : 18'(signed'(wdata[15:0]));
		xp = 18'(signed'(q.xprev));
		tilt = 32'(x) - 32'(mulq(q.kappa, xp));
		t16 = 18'(signed'(sat16(tilt)));
		n3 = mulq(18'(signed'(q.lfsr)), `UEN_SQRT3);
		rn = mulq(q.gain, n3);
		mix = 32'(mulq(q.ascale, t16)) + 32'(mulq(`UEN_Q_ONE - q.alpha, rn));
		sq = 32'(32'(x) * 32'(x)) >> 8;
		cr = (32'(x) * 32'(xp)) >>> 8;
		r0n = q.r0 + sq;
		r1n = q.r1 + cr;
		fmid = (18'(signed'(q.lf_prev[li])) + 18'(signed'(q.lf_cur[li]))) >>> 1;
		d.pready = acc && !q.pready && (q.state == uen_pkg::S_IDLE);
		if (d.pready) begin
			d.prdata = 32'h00000000;
			if (addr == `UEN_OFS_CFG) begin
				d.prdata = {4'h0, q.rate, 13'h0000, q.unv_mode, q.bw};
			end else if (addr == `UEN_OFS_LSP_SEL) begin
				d.prdata = {28'h0000000, q.lsp_sel};
			end else if (addr == `UEN_OFS_OUT_PREV) begin
				d.prdata = {16'h0000, sat16(32'(blend(18'(signed'(q.lf_prev[li])),
					18'(signed'(q.dec_prev[li])), q.alpha)))};
			end else if (addr == `UEN_OFS_OUT_MID) begin
				d.prdata = {16'h0000, sat16(32'(blend(fmid, 18'(signed'(q.dec_mid[li])), q.alpha)))};
			end else if (addr == `UEN_OFS_OUT_END) begin
				d.prdata = {16'h0000, sat16(32'(blend(18'(signed'(q.lf_cur[li])),
					18'(signed'(q.dec_cur[li])), q.alpha)))};
			end else if (addr == `UEN_OFS_EXC_OUT) begin
				d.prdata = {16'h0000, q.exc_out};
			end else if (addr == `UEN_OFS_STATUS) begin
				d.prdata = {q.gamma[15:0], q.ctl, q.act_cnt, q.hang_cnt, q.phase_n, q.hang_done, 1'b0, q.smooth_on};
			end else if (addr == `UEN_OFS_FACTOR) begin
				d.prdata = {q.gain[15:0], q.alpha[15:0]};
			end else if (addr == `UEN_OFS_KAPPA) begin
				d.prdata = {16'h0000, q.kappa[15:0]};
			end else if (addr == `UEN_OFS_UNV_PARAM) begin
				d.prdata = {12'h000, q.unv_param};
			end else if (addr != `UEN_OFS_FRAME && addr != `UEN_OFS_LSP_END && addr != `UEN_OFS_LSP_MID
				&& addr != `UEN_OFS_EXC_IN) begin
				d.pslverr = 1'b1;
			end
		end
		case (q.state)
			uen_pkg::S_IDLE: begin
				if (wr) begin
					if (addr == `UEN_OFS_CFG) begin
						d.bw = wdata[1:0];
						d.unv_mode = wdata[2];
						d.rate = wdata[27:16];
					end else if (addr == `UEN_OFS_FRAME) begin
						d.nu = wdata[15:0];
						d.act = wdata[16];
						d.erased = wdata[17];
						d.idx = 4'h0;
						d.smp_cnt = 8'h00;
						// Sums restart so that a cut frame never leaks into the next RMS or tilt.
						d.energy = 32'h00000000;
						d.r0 = 32'h00000000;
						d.r1 = 32'sh00000000;
						d.state = uen_pkg::S_LSP;
					end else if (addr == `UEN_OFS_LSP_END) begin
						d.in_end[wdata[19:16]] = wdata[15:0];
					end else if (addr == `UEN_OFS_LSP_MID) begin
						d.in_mid[wdata[19:16]] = wdata[15:0];
					end else if (addr == `UEN_OFS_LSP_SEL) begin
						d.lsp_sel = wdata[3:0];
					end else if (addr == `UEN_OFS_UNV_PARAM) begin
						d.unv_param = wdata[19:0];
					end else if (addr == `UEN_OFS_EXC_IN) begin
						// Disabled smoothing leaves the sample unchanged: the received data, or the innovation in unvoiced mode.
						d.exc_out = q.smooth_on ? sat16(mix) : x[15:0];
						d.xprev = x[15:0];
						d.lfsr = q.lfsr[0] ? ((q.lfsr >> 1) ^ `UEN_LFSR_TAPS) : (q.lfsr >> 1);
						d.smp_cnt = q.smp_cnt + 8'h01;
						d.energy = q.energy + sq;
						d.r0 = r0n;
						d.r1 = r1n;
						// Kappa is taken from the finished subframe and steers the next one.
						if (q.smp_cnt[5:0] == `UEN_SUB_LAST) begin
							d.div_num = r1n[31] ? 32'(-r1n) : 32'(r1n);
							d.div_den = r0n;
							d.div_go = 1'b1;
							d.kneg = r1n[31];
							d.last = (q.smp_cnt == `UEN_FRAME_LAST);
							d.r0 = 32'h00000000;
							d.r1 = 32'sh00000000;
							d.state = uen_pkg::S_KAPPA;
						end
					end
				end
			end
			uen_pkg::S_LSP: begin
				d.lf_prev[q.idx] = q.lf_cur[q.idx];
				d.lf_cur[q.idx] = 16'(mulq(`UEN_LP_KEEP, 18'(signed'(q.lf_cur[q.idx])))
					+ mulq(`UEN_LP_NEW, 18'(signed'(q.in_end[q.idx]))));
				d.dec_prev[q.idx] = q.dec_cur[q.idx];
				d.dec_cur[q.idx] = q.in_end[q.idx];
				d.dec_mid[q.idx] = q.in_mid[q.idx];
				d.idx = q.idx + 4'h1;
				if (q.idx == `UEN_LSP_LAST) begin
					d.state = uen_pkg::S_CTRL;
				end
			end
			uen_pkg::S_CTRL: begin
				if (g < $signed({2'b00, q.nu})) begin
					g = 18'(q.nu);
				end
				if (!q.erased) begin
					d.gamma = g;
				end
				if (q.act) begin
					d.ctl = uen_pkg::C_OFF;
					d.act_cnt = (q.act_cnt == 3'h7) ? q.act_cnt : q.act_cnt + 3'h1;
				end else begin
					d.act_cnt = 3'h0;
					case (q.ctl)
						uen_pkg::C_OFF: begin
							if (q.hang_done && q.act_cnt <= `UEN_BURST_MAX) begin
								d.ctl = uen_pkg::C_FULL;
							end else begin
								d.ctl = uen_pkg::C_HANG;
								d.hang_done = 1'b0;
								d.hang_cnt = 3'h1;
								d.phase_n = 3'h0;
							end
						end
						uen_pkg::C_HANG: begin
							if (q.hang_cnt == `UEN_HANG_LEN) begin
								d.ctl = uen_pkg::C_PHASE;
								d.hang_done = 1'b1;
								d.phase_n = 3'h1;
							end else begin
								d.hang_cnt = q.hang_cnt + 3'h1;
							end
						end
						uen_pkg::C_PHASE: begin
							if (q.phase_n == `UEN_PHASE_LEN) begin
								d.ctl = uen_pkg::C_FULL;
							end else begin
								d.phase_n = q.phase_n + 3'h1;
							end
						end
						default: begin
							d.ctl = uen_pkg::C_FULL;
						end
					endcase
				end
				on = (d.ctl == uen_pkg::C_PHASE || d.ctl == uen_pkg::C_FULL) && rate_ok;
				d.smooth_on = on;
				if (!on) begin
					d.alpha = `UEN_Q_ONE;
				end else if (d.ctl == uen_pkg::C_PHASE) begin
					d.alpha = `UEN_Q_ONE - mulq(`UEN_Q_ONE - d.gamma, 18'(d.phase_n) * `UEN_PHASE_RECIP);
				end else begin
					d.alpha = d.gamma;
				end
				pa = d.alpha * d.alpha;
				pw = (`UEN_Q_ONE - d.alpha) * (`UEN_Q_ONE - d.alpha);
				d.sq_x = pa[31:0] + pw[31:0];
				d.sq_go = 1'b1;
				d.state = uen_pkg::S_NORM;
			end
			uen_pkg::S_NORM: begin
				if (sq_done) begin
					d.div_num = {16'h0000, q.alpha[15:0]};
					d.div_den = {16'h0000, sq_root};
					d.div_go = 1'b1;
					d.state = uen_pkg::S_SCALE;
				end
			end
			uen_pkg::S_SCALE: begin
				if (div_done) begin
					d.ascale = 18'(div_quot);
					d.state = uen_pkg::S_IDLE;
				end
			end
			uen_pkg::S_KAPPA: begin
				if (div_done) begin
					d.kappa = q.kneg ? -18'(div_quot) : 18'(div_quot);
					if (q.last) begin
						d.sq_x = q.energy;
						d.sq_go = 1'b1;
						d.state = uen_pkg::S_RMS;
					end else begin
						d.state = uen_pkg::S_IDLE;
					end
				end
			end
			uen_pkg::S_RMS: begin
				if (sq_done) begin
					d.gain = mulq(`UEN_LP_KEEP, q.gain) + mulq(`UEN_LP_NEW, 18'(sq_root));
					d.energy = 32'h00000000;
					d.state = uen_pkg::S_IDLE;
				end
			end
			default: begin
				d.state = uen_pkg::S_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.state <= uen_pkg::S_IDLE;
			q.ctl <= uen_pkg::C_OFF;
			q.gamma <= `UEN_Q_ONE;
			q.alpha <= `UEN_Q_ONE;
			q.lfsr <= `UEN_LFSR_SEED;
		end else begin
			q <= d;
		end
	end

	assign apb_rsp = '{prdata: q.prdata, pready: q.pready, pslverr: q.pslverr};

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	a_rate_gate: assert property ((q.state == uen_pkg::S_CTRL && !rate_ok) |=> !q.smooth_on)
		else $error("smoothing enabled at a rate that forbids it");
	a_lsp_shift: assert property ((q.state == uen_pkg::S_LSP) |=> q.lf_prev[$past(q.idx)] == $past(q.lf_cur[q.idx]))
		else $error("filtered lsp history not shifted");
	a_kappa_sub: assert property ($rose(q.state == uen_pkg::S_KAPPA) |-> q.smp_cnt[5:0] == 6'h00)
		else $error("kappa update off a subframe boundary");
	a_gain_frame: assert property ($changed(q.gain) |-> $past(q.state == uen_pkg::S_RMS))
		else $error("noise gain changed outside the frame update");
	a_gamma_floor: assert property ((q.state == uen_pkg::S_CTRL && !q.erased) |=> q.gamma >= $signed({2'b00, q.nu}))
		else $error("gamma below noisiness");
	a_gamma_hold: assert property ((q.state == uen_pkg::S_CTRL && q.erased) |=> $stable(q.gamma))
		else $error("gamma changed on an erased frame");
	a_hang_five: assert property ($rose(q.ctl == uen_pkg::C_PHASE) |-> $past(q.hang_cnt) == 3'h5)
		else $error("phase-in began before five hangover frames");
	a_active_off: assert property ((q.state == uen_pkg::S_CTRL && q.act) |=> !q.smooth_on ##1 q.alpha == 18'sh08000)
		else $error("active frame left smoothing on");
	a_phase_range: assert property ((q.smooth_on && q.ctl == uen_pkg::C_PHASE) |-> q.alpha >= q.gamma)
		else $error("phase-in factor passed gamma");
	a_full_gamma: assert property ((q.smooth_on && q.ctl == uen_pkg::C_FULL) |-> q.alpha == q.gamma)
		else $error("full smoothing factor differs from gamma");
	a_pass_thru: assert property ((wr && addr == 8'h20 && !q.smooth_on && !q.unv_mode && q.state == uen_pkg::S_IDLE)
		|=> q.exc_out == $past(wdata[15:0]))
		else $error("sample altered while smoothing is off");

	c_smooth_on: cover property ($rose(q.smooth_on));
	c_resume: cover property ($past(q.ctl == uen_pkg::C_OFF) && q.ctl == uen_pkg::C_FULL);
	c_rms: cover property (q.state == uen_pkg::S_RMS ##1 q.state == uen_pkg::S_IDLE);
	c_erased: cover property (q.state == uen_pkg::S_CTRL && q.erased);

endmodule

// ==== design/uen_div.sv ====
// Sequential Q15 fraction divider: quotient of num over den, saturating at one.
`timescale 1ns/1ps

module uen_div (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Request
	input  wire logic        go,
	input  wire logic [31:0] num,
	input  wire logic [31:0] den,
	// Result
	output logic             done,
	output logic [15:0]      quot
);

	uen_pkg::uen_div_st_type q;
	uen_pkg::uen_div_st_type d;
	logic [32:0]             r2;

	always_comb begin
		d = q;
		d.done = 1'b0;
		r2 = {q.rem[31:0], 1'b0};
		if (go) begin
			d.den = den;
			d.quot = 16'h0000;
			// A zero divisor yields zero so an all-silent subframe gives no tilt.
			if (den == 32'h00000000) begin
				d.done = 1'b1;
			end else if (num >= den) begin
				d.quot = 16'h7fff;
				d.done = 1'b1;
			end else begin
				d.rem = {1'b0, num};
				d.cnt = 4'hf;
				d.busy = 1'b1;
			end
		end else if (q.busy) begin
			if (r2 >= {1'b0, q.den}) begin
				d.rem = r2 - {1'b0, q.den};
				d.quot = {q.quot[14:0], 1'b1};
			end else begin
				d.rem = r2;
				d.quot = {q.quot[14:0], 1'b0};
			end
			d.cnt = q.cnt - 4'h1;
			if (q.cnt == 4'h1) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign done = q.done;
	assign quot = q.quot;

endmodule

// ==== design/uen_params.svh ====
// Constants: register offsets, reset values, fixed-point factors and frame counts.
`ifndef UEN_PARAMS_SVH
`define UEN_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define UEN_OFS_CFG      8'h00
`define UEN_OFS_FRAME    8'h04
`define UEN_OFS_LSP_END  8'h08
`define UEN_OFS_LSP_MID  8'h0c
`define UEN_OFS_LSP_SEL  8'h10
`define UEN_OFS_OUT_PREV 8'h14
`define UEN_OFS_OUT_MID  8'h18
`define UEN_OFS_OUT_END  8'h1c
`define UEN_OFS_EXC_IN   8'h20
`define UEN_OFS_EXC_OUT  8'h24
`define UEN_OFS_STATUS   8'h28
`define UEN_OFS_FACTOR   8'h2c
`define UEN_OFS_KAPPA    8'h30
`define UEN_OFS_UNV_PARAM 8'h34

// ----------------------------------------------------------------------------
// Fixed-point factors (Q15 in an 18-bit signed word)
// ----------------------------------------------------------------------------
`define UEN_Q_ONE        18'sh08000
`define UEN_LP_KEEP      18'sh07333
`define UEN_LP_NEW       18'sh00ccd
`define UEN_GAMMA_STEP   18'sh00666
`define UEN_PHASE_RECIP  18'sh0199a
`define UEN_SQRT3        18'sh0ddb4

// ----------------------------------------------------------------------------
// Frame counts, limits and reset values
// ----------------------------------------------------------------------------
`define UEN_HANG_LEN     3'h5
`define UEN_PHASE_LEN    3'h5
`define UEN_BURST_MAX    3'h3
`define UEN_RATE_LIMIT   12'h060
`define UEN_BW_NB        2'h0
`define UEN_LSP_LAST     4'hf
`define UEN_SUB_LAST     6'h3f
`define UEN_FRAME_LAST   8'hff
`define UEN_LFSR_SEED    16'hace1
`define UEN_LFSR_TAPS    16'hb400

`endif

// ==== design/uen_pkg.sv ====
// Types shared by the smoothing core and its arithmetic helpers.
package uen_pkg;

	// ------------------------------------------------------------------------
	// Enumerations
	// ------------------------------------------------------------------------
	typedef enum logic [6:0] {
		S_IDLE  = 7'h01,
		S_LSP   = 7'h02,
		S_CTRL  = 7'h04,
		S_NORM  = 7'h08,
		S_SCALE = 7'h10,
		S_KAPPA = 7'h20,
		S_RMS   = 7'h40
	} uen_state_type;

	typedef enum logic [3:0] {
		C_OFF   = 4'h1,
		C_HANG  = 4'h2,
		C_PHASE = 4'h4,
		C_FULL  = 4'h8
	} uen_ctl_type;

	typedef logic signed [17:0] uen_q_type;
	typedef logic [15:0][15:0]  uen_lsp_type;

	// ------------------------------------------------------------------------
	// Bus carriers
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} uen_apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} uen_apb_rsp_type;

	// ------------------------------------------------------------------------
	// Module state
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic        busy;
		logic        done;
		logic [32:0] rem;
		logic [31:0] den;
		logic [15:0] quot;
		logic [3:0]  cnt;
	} uen_div_st_type;

	typedef struct packed {
		logic        busy;
		logic        done;
		logic [31:0] x;
		logic [15:0] res;
		logic [15:0] bitm;
	} uen_sqrt_st_type;

	typedef struct packed {
		uen_state_type state;
		uen_ctl_type   ctl;
		logic [1:0]    bw;
		logic [11:0]   rate;
		logic          unv_mode;
		logic [19:0]   unv_param;
		logic [15:0]   nu;
		logic          act;
		logic          erased;
		uen_q_type     gamma;
		uen_q_type     alpha;
		uen_q_type     ascale;
		uen_q_type     kappa;
		uen_q_type     gain;
		logic          smooth_on;
		logic          hang_done;
		logic [2:0]    hang_cnt;
		logic [2:0]    phase_n;
		logic [2:0]    act_cnt;
		logic [3:0]    idx;
		logic [3:0]    lsp_sel;
		uen_lsp_type   lf_prev;
		uen_lsp_type   lf_cur;
		uen_lsp_type   dec_prev;
		uen_lsp_type   dec_cur;
		uen_lsp_type   dec_mid;
		uen_lsp_type   in_end;
		uen_lsp_type   in_mid;
		logic [15:0]   xprev;
		logic [15:0]   lfsr;
		logic [7:0]    smp_cnt;
		logic [31:0]   energy;
		logic [31:0]   r0;
		logic signed [31:0] r1;
		logic          kneg;
		logic          last;
		logic [15:0]   exc_out;
		logic          div_go;
		logic [31:0]   div_num;
		logic [31:0]   div_den;
		logic          sq_go;
		logic [31:0]   sq_x;
		logic [31:0]   prdata;
		logic          pready;
		logic          pslverr;
	} uen_core_st_type;

endpackage

// ==== design/uen_sqrt.sv ====
// Sequential integer square root, one result bit per clock.
`timescale 1ns/1ps

module uen_sqrt (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Request
	input  wire logic        go,
	input  wire logic [31:0] radicand,
	// Result
	output logic             done,
	output logic [15:0]      root
);

	uen_pkg::uen_sqrt_st_type q;
	uen_pkg::uen_sqrt_st_type d;
	logic [15:0]              trial;
	logic [31:0]              sq;

	always_comb begin
		d = q;
		d.done = 1'b0;
		trial = q.res | q.bitm;
		sq = trial * trial;
		if (go) begin
			d.x = radicand;
			d.res = 16'h0000;
			d.bitm = 16'h8000;
			d.busy = 1'b1;
		end else if (q.busy) begin
			if (sq <= q.x) begin
				d.res = trial;
			end
			d.bitm = q.bitm >> 1;
			if (q.bitm == 16'h0001) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign done = q.done;
	assign root = q.res;

endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the smoothing core over its register bus.
`timescale 1ns/1ps
`include "uen_params.svh"

module testbench;
	logic                     ref_clk;
	logic                     rst;
	uen_pkg::uen_apb_req_type apb_req;
	uen_pkg::uen_apb_rsp_type apb_rsp;
	int                       bad_count;
	int                       n_compared;
	int                       k;
	logic [31:0]              rd_q;
	logic                     err_q;
	logic [15:0]              g_q;
	logic [15:0]              v_q;

	uen_core u_dut (.ref_clk(ref_clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp));
	uen_apb_host u_host (.ref_clk(ref_clk), .req(apb_req), .rsp(apb_rsp));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic end_sim(input logic hung);
		if (hung) bad_count++;
		if (bad_count == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Fixed-point rounding leaves a few LSB of slack against the ideal value.
	task automatic near(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if ($isunknown(got) || got > exp + 16'h0008 || got + 16'h0008 < exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d, rd_q, err_q);
	endtask

	task automatic rdf(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		u_host.xfer(1'b0, a, 32'h0, rd_q, err_q);
		chk(what, exp, rd_q & m);
	endtask

	// Each frame write is followed by a status read, which waits out the update.
	task automatic frame(input logic [31:0] d, input logic [31:0] m, input logic [31:0] exp);
		wr(`UEN_OFS_FRAME, d);
		rdf("status", `UEN_OFS_STATUS, m, exp);
	endtask

	// ------------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------------
	initial begin
		rst = 1'b1;
		bad_count = 0;
		n_compared = 0;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		rdf("status", `UEN_OFS_STATUS, 32'hfffff001, 32'h80001000);
		rdf("alpha", `UEN_OFS_FACTOR, 32'h0000ffff, 32'h00008000);
		u_host.xfer(1'b0, 8'hfc, 32'h0, rd_q, err_q);
		chk("slverr", 32'h1, {31'h0, err_q});
		wr(`UEN_OFS_UNV_PARAM, 32'h0005a5a5);
		rdf("unv_param", `UEN_OFS_UNV_PARAM, 32'h000fffff, 32'h0005a5a5);
		wr(`UEN_OFS_EXC_IN, 32'h0000a5c3);
		rdf("exc", `UEN_OFS_EXC_OUT, 32'h0000ffff, 32'h0000a5c3);
		wr(`UEN_OFS_CFG, 32'h00600000);
		for (k = 1; k <= 5; k++) begin
			frame(32'h4000, 32'h1, 32'h0);
			g_q = 16'h8000 - 16'(k) * 16'h0666;
			rdf("gamma", `UEN_OFS_STATUS, 32'hffff0000, {g_q, 16'h0});
		end
		for (k = 1; k <= 5; k++) frame(32'h4000, 32'hf039, {16'h0, 4'h4, 6'h0, k[2:0], 3'h1});
		frame(32'h4000, 32'hf001, 32'h8001);
		rdf("alpha", `UEN_OFS_FACTOR, 32'h0000ffff, 32'h00004000);
		frame(32'h20000, 32'hffff0001, 32'h40000001);
		frame(32'h0, 32'hffff0001, 32'h399a0001);
		frame(32'h10000, 32'h1, 32'h0);
		rdf("alpha", `UEN_OFS_FACTOR, 32'h0000ffff, 32'h00008000);
		frame(32'h10000, 32'h1, 32'h0);
		frame(32'h0, 32'hf001, 32'h8001);
		wr(`UEN_OFS_CFG, 32'h00500000);
		frame(32'h0, 32'h1, 32'h0);
		wr(`UEN_OFS_CFG, 32'h00500001);
		frame(32'h0, 32'h1, 32'h1);
		// Gamma has stepped down to 0x199c; noise gain and kappa are still zero here.
		rdf("alpha", `UEN_OFS_FACTOR, 32'h0000ffff, 32'h0000199c);
		wr(`UEN_OFS_EXC_IN, 32'h00004000);
		u_host.xfer(1'b0, `UEN_OFS_EXC_OUT, 32'h0, rd_q, err_q);
		near("mix", 16'h0f87, rd_q[15:0]);
		// Unvoiced innovation with smoothing off: data ignored, signs negate, one gain step doubles.
		wr(`UEN_OFS_CFG, 32'h00500005);
		wr(`UEN_OFS_LSP_END, 32'h00001111);
		frame(32'h10000, 32'h1, 32'h0);
		wr(`UEN_OFS_EXC_IN, 32'h00001234);
		u_host.xfer(1'b0, `UEN_OFS_EXC_OUT, 32'h0, rd_q, err_q);
		v_q = rd_q[15:0];
		chk("innov_zero", 32'h0, {31'h0, v_q == 16'h0000});
		chk("innov_data", 32'h0, {31'h0, v_q == 16'h1234});
		wr(`UEN_OFS_LSP_END, 32'h00002222);
		wr(`UEN_OFS_LSP_MID, 32'h00000333);
		frame(32'h10000, 32'h1, 32'h0);
		rdf("lsp_prev", `UEN_OFS_OUT_PREV, 32'h0000ffff, 32'h00001111);
		rdf("lsp_mid", `UEN_OFS_OUT_MID, 32'h0000ffff, 32'h00000333);
		rdf("lsp_end", `UEN_OFS_OUT_END, 32'h0000ffff, 32'h00002222);
		wr(`UEN_OFS_UNV_PARAM, 32'h00052525);
		wr(`UEN_OFS_EXC_IN, 32'h00001234);
		rdf("innov_sign", `UEN_OFS_EXC_OUT, 32'h0000ffff, {16'h0, -v_q});
		frame(32'h10000, 32'h1, 32'h0);
		wr(`UEN_OFS_UNV_PARAM, 32'h0006a5a5);
		wr(`UEN_OFS_EXC_IN, 32'h00001234);
		rdf("innov_gain", `UEN_OFS_EXC_OUT, 32'h0000ffff, {16'h0, v_q << 1});
		// A steady frame of 0x1000: kappa saturates at one, gain takes a tenth of the RMS.
		wr(`UEN_OFS_CFG, 32'h00500001);
		frame(32'h10000, 32'h1, 32'h0);
		for (k = 0; k < 256; k++) wr(`UEN_OFS_EXC_IN, 32'h00001000);
		rdf("kappa", `UEN_OFS_KAPPA, 32'h0000ffff, 32'h00007fff);
		rdf("gain", `UEN_OFS_FACTOR, 32'hffff0000, 32'h01990000);
		end_sim(1'b0);
	end
endmodule

// ==== testbench/uen_apb_host.sv ====
// Register bus master model standing in for the parameter decoder side.
`timescale 1ns/1ps

module uen_apb_host (
	// Clock
	input  wire logic                     ref_clk,
	// Register bus
	output uen_pkg::uen_apb_req_type      req,
	input  wire uen_pkg::uen_apb_rsp_type rsp
);
	// ------------------------------------------------------------------
	// Transfer
	// ------------------------------------------------------------------
	initial req = '0;

	// The wait is bounded so that a slave that never answers ends the run.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge ref_clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge ref_clk);
		req.penable <= 1'b1;
		for (n = 0; n < 2000; n++) begin
			@(posedge ref_clk);
			if (rsp.pready === 1'b1) break;
		end
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~w, paddr: ~a, pwdata: ~d};
		if (n == 2000) testbench.end_sim(1'b1);
	endtask
endmodule
